// *** testbench/smbus_host_model.sv ***
// smbus host model for the expander link
`timescale 1ns/100ps
`default_nettype none

module smbus_host_model (
    input wire logic i_link_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda
);
    initial
    begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge i_link_clk);
        #1;
    endtask : wt

    task automatic bit_x(input logic b, output logic r);
        wt(3);
        o_sda = b;
        wt(6);
        o_scl = 1'b1;
        wt(9);
        r = i_sda;
        o_scl = 1'b0;
    endtask : bit_x

    // start when first is 1, stop when 0
    task automatic cond(input logic first);
        wt(3);
        o_sda = first;
        wt(3);
        o_scl = 1'b1;
        wt(6);
        o_sda = !first;
        wt(6);
    endtask : cond

    task automatic byte_x(input logic [7:0] d, output logic [7:0] q, output logic k);
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], q[i]);
        bit_x(1'b1, k);
    endtask : byte_x

    // kind: 0 write, 1 read, 2 send, 3 receive
    task automatic xfer(input logic [6:0] a, input logic [7:0] cmd, input logic [7:0] wd,
                        input logic [1:0] kind, output logic [7:0] rd, output logic nak);
        logic [7:0] q;
        logic k;
        nak = 1'b0;
        cond(1'b1);
        o_scl = 1'b0;
        if (kind != 2'd3)
        begin
            byte_x({a, 1'b0}, q, k);
            nak |= k;
            byte_x(cmd, q, k);
            nak |= k;
            if (kind == 2'd0)
                byte_x(wd, q, k);
            nak |= (kind == 2'd0) & k;
            if (kind == 2'd1)
            begin
                cond(1'b1);
                o_scl = 1'b0;
            end
        end
        // receive with released ack; on receive-byte wd plays a rival slave
        if (kind[0])
        begin
            byte_x({a, 1'b1}, q, k);
            nak |= k;
            byte_x(kind[1] ? wd : 8'hff, rd, k);
        end
        cond(1'b0);
    endtask : xfer
endmodule : smbus_host_model
`default_nettype wire

// *** testbench/smbus_io_expander_core_test.sv ***
// self-checking bench of the smbus i/o expander core
`timescale 1ns/100ps
`default_nettype none

module smbus_io_expander_core_test;
    localparam logic [7:0] ID = 8'h5a;
    logic ref_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n = 1'b0;
    logic scl, host_sda, sda, sda_oe, alert_oe, suspend, thermal;
    logic [7:0] ext, io_oe, rd, io_out;
    logic [3:0] addr_pin;
    logic [6:0] dev;
    logic nak, sda_out;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;

    always #50 ref_clk = ~ref_clk;
    initial
    begin
        #3;
        forever #6 link_clk = ~link_clk;
    end
    assign sda = host_sda & ~sda_oe;

    smbus_host_model host (.i_link_clk(link_clk), .i_sda(sda), .o_scl(scl), .o_sda(host_sda));

    smbus_io_expander_core #(.OUT_START_HIGH(1'b0), .MAKER_ID(ID)) uut (
        .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_link_clk(link_clk), .i_scl(scl),
        .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_alert_oe(alert_oe),
        .i_io_pin(ext & ~io_oe), .o_io_out(io_out), .o_io_oe(io_oe),
        .i_suspend_select(suspend), .i_thermal_fault(thermal), .i_addr_pin(addr_pin));

    task automatic results();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : settle

    task automatic reg_wr(input logic [7:0] cmd, input logic [7:0] d);
        host.xfer(dev, cmd, d, 2'd0, rd, nak);
        check("write ack", {7'h00, nak}, 8'h00);
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] cmd, input logic [7:0] exp);
        host.xfer(dev, cmd, 8'h00, 2'd1, rd, nak);
        check("read", rd, exp);
    endtask : reg_rd

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            errors++;
            results();
        end
    end

    initial
    begin
        ext = 8'h00;
        suspend = 1'b1;
        thermal = 1'b0;
        addr_pin = 4'h3;
        dev = 7'h23;
        settle(6);
        rst_n = 1'b1;
        settle(4);
        check("io_oe", io_oe, 8'hff);
        check("io_out", io_out, 8'h00);
        check("sda_out", {7'h00, sda_out}, 8'h00);
        for (int c = 0; c < 6; c++)
            reg_rd(8'(c), (c == 0 || c == 3) ? 8'h00 : 8'hff);
        reg_rd(smbus_io_expander_pkg::CMD_MAKER_ID, ID);
        reg_wr(smbus_io_expander_pkg::CMD_PIN_LEVEL, 8'hff);
        reg_rd(smbus_io_expander_pkg::CMD_NORMAL_OUT, 8'hff);
        reg_wr(smbus_io_expander_pkg::CMD_SUSPEND_OUT, 8'h0f);
        settle(10);
        check("io_oe", io_oe, 8'h00);
        suspend = 1'b0;
        settle(8);
        check("io_oe", io_oe, 8'hf0);
        suspend = 1'b1;
        ext = 8'h5a;
        settle(8);
        reg_rd(smbus_io_expander_pkg::CMD_PIN_LEVEL, 8'h5a);
        ext = 8'h00;
        settle(8);
        check("alert", {7'h00, alert_oe}, 8'h00);
        reg_wr(smbus_io_expander_pkg::CMD_NORMAL_RISE, 8'hfe);
        ext = 8'h01;
        settle(8);
        check("alert", {7'h00, alert_oe}, 8'h01);
        reg_wr(smbus_io_expander_pkg::CMD_NORMAL_RISE, 8'hff);
        settle(8);
        check("alert", {7'h00, alert_oe}, 8'h01);
        host.xfer(7'h19, 8'h00, 8'hff, 2'd3, rd, nak);
        check("alert answer", rd, {dev, 1'b0});
        settle(10);
        check("alert", {7'h00, alert_oe}, 8'h00);
        reg_rd(smbus_io_expander_pkg::CMD_NORMAL_RISE, 8'hff);
        reg_wr(smbus_io_expander_pkg::CMD_NORMAL_FALL, 8'hfe);
        ext = 8'h00;
        settle(8);
        check("alert", {7'h00, alert_oe}, 8'h01);
        host.xfer(dev, smbus_io_expander_pkg::CMD_SOFT_POR, 8'h00, 2'd2, rd, nak);
        settle(10);
        check("alert", {7'h00, alert_oe}, 8'h00);
        check("io_oe", io_oe, 8'hff);
        reg_rd(smbus_io_expander_pkg::CMD_NORMAL_FALL, 8'hff);
        thermal = 1'b1;
        settle(8);
        check("alert", {7'h00, alert_oe}, 8'h01);
        check("io_oe", io_oe, 8'h00);
        thermal = 1'b0;
        settle(8);
        // rival slave at 21h answers too and wins the arbitration
        host.xfer(7'h19, 8'h00, {7'h21, 1'b0}, 2'd3, rd, nak);
        check("alert rival", rd, {7'h21, 1'b0});
        settle(10);
        check("alert", {7'h00, alert_oe}, 8'h01);
        host.xfer(7'h19, 8'h00, 8'hff, 2'd3, rd, nak);
        check("alert answer", rd, {dev, 1'b0});
        settle(10);
        check("alert", {7'h00, alert_oe}, 8'h00);
        addr_pin = 4'h5;
        host.xfer(dev, smbus_io_expander_pkg::CMD_ADDR_RESAMPLE, 8'h00, 2'd2, rd, nak);
        dev = 7'h25;
        reg_rd(smbus_io_expander_pkg::CMD_MAKER_ID, ID);
        results();
    end
endmodule : smbus_io_expander_core_test
`default_nettype wire

// *** verilog/smbus_io_expander_core.sv ***
// register, alert and pin logic of the eight-line smbus i/o expander
//
// Behaviour
// R1: suspend_select low uses suspend set, high normal
// R2: unmasked pin edge or thermal raises alert
// R3: rise mask bit 1 masks, 0 enables
// R4: fall mask bit 1 masks, 0 enables
// R5: all mask registers reset to ones
// R6: thermal interrupt ignores every mask bit
// R7: soft reset or won alert response clears
// R8: masking later never clears pending interrupt
// R9: alert response returns own slave address
// R10: alert arbitration bitwise, loser releases bus
// R11: loser keeps alert until it wins later
// R12: clearing interrupt leaves registers untouched
// R13: commands 00h-05h select the six registers
// R14: output bit 0 drives low, 1 releases
// R15: output registers reset per power-up variant
// R16: command 06h reads live pin levels
// R17: command 07h resamples address pins
// R18: command 08h restores power-on state, resamples; a write-byte to 08h leaves its data byte in register 00h
// R19: command FEh reads fixed maker byte
// R20: pins sampled only during readback
// R21: power-on and undervoltage restore pin states
// R22: pins captured at read acknowledge falling edge
// R23: writes to read-only commands go output register
// R24: command pointer survives soft reset
// R25: synchronized pins compared, edges latched pending
`timescale 1ns/100ps
`default_nettype none

module smbus_io_expander_core #(
    parameter logic OUT_START_HIGH = 1'b0,
    // arbitrary neutral value
    parameter logic [7:0] MAKER_ID = 8'h5a
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_link_clk,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    output logic o_alert_oe,
    input wire logic [7:0] i_io_pin,
    output logic [7:0] o_io_out,
    output logic [7:0] o_io_oe,
    input wire logic i_suspend_select,
    input wire logic i_thermal_fault,
    input wire logic [3:0] i_addr_pin
);

    localparam logic [7:0] OUT_RESET = OUT_START_HIGH ?
        smbus_io_expander_pkg::OUT_RESET_HIGH : smbus_io_expander_pkg::OUT_RESET_LOW;
    localparam logic [47:0] CFG_RESET = {
        smbus_io_expander_pkg::MASK_RESET, smbus_io_expander_pkg::MASK_RESET, OUT_RESET,
        smbus_io_expander_pkg::MASK_RESET, smbus_io_expander_pkg::MASK_RESET, OUT_RESET};

    // ****************************************
    // link side: synchronisers
    // ****************************************
    logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
    logic [7:0] lpin_m, lpin_s;
    logic [3:0] addr_m, addr_s;
    logic alert_m, alert_s, ack_m, ack_s, req_seen;

    always_ff @(posedge i_link_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            {scl_m, scl_s, scl_d} <= 3'h7;
            {sda_m, sda_s, sda_d} <= 3'h7;
            lpin_m <= 8'h00;
            lpin_s <= 8'h00;
            addr_m <= 4'h0;
            addr_s <= 4'h0;
            {alert_m, alert_s, ack_m, ack_s} <= 4'h0;
        end
        else
        begin
            {scl_m, scl_s, scl_d} <= {i_scl, scl_m, scl_s};
            {sda_m, sda_s, sda_d} <= {i_sda, sda_m, sda_s};
            lpin_m <= i_io_pin;
            lpin_s <= lpin_m;
            addr_m <= i_addr_pin;
            addr_s <= addr_m;
            {alert_m, alert_s, ack_m, ack_s} <= {o_alert_oe, alert_m, req_seen, ack_m};
        end
    end

    wire logic scl_rise = scl_s & ~scl_d;
    wire logic scl_fall = ~scl_s & scl_d;
    wire logic start_evt = scl_s & scl_d & sda_d & ~sda_s;
    wire logic stop_evt = scl_s & scl_d & ~sda_d & sda_s;

    // ****************************************
    // link side: slave state machine
    // ****************************************
    smbus_io_expander_pkg::link_state_e st;
    logic [3:0] bit_cnt;
    logic [7:0] shift, tx, cmd_ptr;
    logic rw, is_ara, lost, cmd_only;
    logic [6:0] own_addr;
    logic addr_loaded, req_tgl, clr_tgl;
    logic [1:0] addr_age;
    logic [7:0] cfg [0:5];
    logic [47:0] xfer_data;

    wire logic edge_ok = scl_fall & ~start_evt & ~stop_evt;
    wire logic byte_done = edge_ok & (bit_cnt == smbus_io_expander_pkg::BYTE_BITS);
    wire logic wr_evt = byte_done & (st == smbus_io_expander_pkg::ST_DATA);
    wire logic send_exec = stop_evt & cmd_only;
    wire logic soft_por = (send_exec | wr_evt) & (cmd_ptr == smbus_io_expander_pkg::CMD_SOFT_POR);
    wire logic resample = soft_por |
        ((send_exec | wr_evt) & (cmd_ptr == smbus_io_expander_pkg::CMD_ADDR_RESAMPLE));
    wire logic ara_win = byte_done & (st == smbus_io_expander_pkg::ST_TX) & is_ara & ~lost;
    wire logic addr_hit = shift[7:1] == own_addr;
    wire logic ara_hit = (shift[7:1] == smbus_io_expander_pkg::ALERT_RESPONSE_ADDR) &
        shift[0] & alert_s;
    wire logic [47:0] cfg_flat = {cfg[5], cfg[4], cfg[3], cfg[2], cfg[1], cfg[0]};

    logic [7:0] rd_byte;
    always_comb
    begin
        // R16 live pins
        if (cmd_ptr == smbus_io_expander_pkg::CMD_PIN_LEVEL)
            rd_byte = lpin_s;
        // R19 fixed maker byte
        else if (cmd_ptr == smbus_io_expander_pkg::CMD_MAKER_ID)
            rd_byte = MAKER_ID;
        else if (cmd_ptr <= smbus_io_expander_pkg::CMD_LAST_DATA)
            rd_byte = cfg[cmd_ptr[2:0]];
        else
            rd_byte = smbus_io_expander_pkg::UNMAPPED_READ;
    end

    always_ff @(posedge i_link_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st <= smbus_io_expander_pkg::ST_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            tx <= 8'h00;
            o_sda_oe <= 1'b0;
            {rw, is_ara, lost, cmd_only} <= 4'h0;
        end
        else if (start_evt)
        begin
            st <= smbus_io_expander_pkg::ST_ADDR;
            bit_cnt <= 4'h0;
            o_sda_oe <= 1'b0;
            {lost, cmd_only} <= 2'h0;
        end
        else if (stop_evt)
        begin
            st <= smbus_io_expander_pkg::ST_IDLE;
            o_sda_oe <= 1'b0;
            cmd_only <= 1'b0;
        end
        else if (scl_rise)
        begin
            if (st == smbus_io_expander_pkg::ST_ADDR || st == smbus_io_expander_pkg::ST_CMD ||
                st == smbus_io_expander_pkg::ST_DATA)
            begin
                shift <= {shift[6:0], sda_s};
                bit_cnt <= bit_cnt + 4'h1;
            end
            // R10 released one seen low
            else if (st == smbus_io_expander_pkg::ST_TX && !o_sda_oe && !sda_s)
                lost <= 1'b1;
        end
        else if (scl_fall)
        begin
            case (st)
                smbus_io_expander_pkg::ST_ADDR:
                    if (bit_cnt == smbus_io_expander_pkg::BYTE_BITS)
                    begin
                        if (addr_hit || ara_hit)
                        begin
                            st <= smbus_io_expander_pkg::ST_ADDR_ACK;
                            o_sda_oe <= 1'b1;
                            rw <= shift[0];
                            // R9 answer only while pending
                            is_ara <= ara_hit & ~addr_hit;
                        end
                        else
                            st <= smbus_io_expander_pkg::ST_IDLE;
                    end
                smbus_io_expander_pkg::ST_ADDR_ACK:
                    if (rw)
                    begin
                        // R20 R22 pins captured at this edge
                        // R9 own address on alert response
                        st <= smbus_io_expander_pkg::ST_TX;
                        o_sda_oe <= is_ara ? ~own_addr[6] : ~rd_byte[7];
                        tx <= is_ara ? {own_addr[5:0], 2'h0} : {rd_byte[6:0], 1'b0};
                        bit_cnt <= 4'h1;
                    end
                    else
                    begin
                        st <= smbus_io_expander_pkg::ST_CMD;
                        o_sda_oe <= 1'b0;
                        bit_cnt <= 4'h0;
                    end
                smbus_io_expander_pkg::ST_CMD:
                    if (bit_cnt == smbus_io_expander_pkg::BYTE_BITS)
                    begin
                        st <= smbus_io_expander_pkg::ST_CMD_ACK;
                        o_sda_oe <= 1'b1;
                        cmd_only <= 1'b1;
                    end
                smbus_io_expander_pkg::ST_CMD_ACK:
                begin
                    st <= smbus_io_expander_pkg::ST_DATA;
                    o_sda_oe <= 1'b0;
                    bit_cnt <= 4'h0;
                end
                smbus_io_expander_pkg::ST_DATA:
                    if (bit_cnt == smbus_io_expander_pkg::BYTE_BITS)
                    begin
                        st <= smbus_io_expander_pkg::ST_DATA_ACK;
                        o_sda_oe <= 1'b1;
                        cmd_only <= 1'b0;
                    end
                smbus_io_expander_pkg::ST_TX:
                    // R10 loser stops driving
                    if (lost)
                    begin
                        st <= smbus_io_expander_pkg::ST_IDLE;
                        o_sda_oe <= 1'b0;
                    end
                    else if (bit_cnt == smbus_io_expander_pkg::BYTE_BITS)
                    begin
                        st <= smbus_io_expander_pkg::ST_TX_ACK;
                        o_sda_oe <= 1'b0;
                    end
                    else
                    begin
                        o_sda_oe <= ~tx[7];
                        tx <= {tx[6:0], 1'b0};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                smbus_io_expander_pkg::ST_DATA_ACK,
                smbus_io_expander_pkg::ST_TX_ACK:
                begin
                    st <= smbus_io_expander_pkg::ST_IDLE;
                    o_sda_oe <= 1'b0;
                end
                default:
                begin
                    st <= smbus_io_expander_pkg::ST_IDLE;
                    o_sda_oe <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_link_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_sda_out <= 1'b0;
        else
            o_sda_out <= 1'b0;
    end

    // ****************************************
    // link side: command pointer and registers
    // ****************************************
    // R24 only power-on resets the pointer
    always_ff @(posedge i_link_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            cmd_ptr <= smbus_io_expander_pkg::CMD_PTR_RESET;
        else if (byte_done && st == smbus_io_expander_pkg::ST_CMD)
            cmd_ptr <= shift;
    end

    always_ff @(posedge i_link_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            // R5 R15 power-on values
            for (int i = 0; i < 6; i++)
                cfg[i] <= CFG_RESET[8*i +: 8];
        end
        else
        begin
            // R18 soft reset restores power-on values; a same-cycle write to 08h still sets cfg[0]
            if (soft_por)
                for (int i = 0; i < 6; i++)
                    cfg[i] <= CFG_RESET[8*i +: 8];
            if (wr_evt)
            begin
                // R13 R23 decode with redirect
                if (cmd_ptr <= smbus_io_expander_pkg::CMD_LAST_DATA)
                    cfg[cmd_ptr[2:0]] <= shift;
                else
                    cfg[0] <= shift;
            end
        end
    end

    // R17 R18 strap capture and resample
    always_ff @(posedge i_link_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            own_addr <= smbus_io_expander_pkg::SLAVE_ADDR_BASE;
            addr_loaded <= 1'b0;
            addr_age <= 2'h0;
        end
        else
        begin
            // first capture waits until the strap synchroniser holds pin values
            addr_age <= {addr_age[0], 1'b1};
            if ((addr_age[1] && !addr_loaded) || resample)
            begin
                own_addr <= smbus_io_expander_pkg::SLAVE_ADDR_BASE + {3'h0, addr_s};
                addr_loaded <= 1'b1;
            end
        end
    end

    // R7 clear request toward pin side
    always_ff @(posedge i_link_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            clr_tgl <= 1'b0;
        else if (ara_win || soft_por)
            clr_tgl <= ~clr_tgl;
    end

    // register set crosses by request/acknowledge toggle
    always_ff @(posedge i_link_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            xfer_data <= CFG_RESET;
            req_tgl <= 1'b0;
        end
        else if (req_tgl == ack_s && xfer_data != cfg_flat)
        begin
            xfer_data <= cfg_flat;
            req_tgl <= ~req_tgl;
        end
    end

    // ****************************************
    // pin side
    // ****************************************
    logic [7:0] pin_m, pin_s, pin_prev;
    logic susp_m, susp_s, therm_m, therm_s;
    logic req_m, req_s, clr_m, clr_s, clr_d;
    logic [47:0] mirror;
    logic [7:0] pend_rise, pend_fall;
    logic pend_therm;

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            pin_m <= 8'h00;
            pin_s <= 8'h00;
            pin_prev <= 8'h00;
            {susp_m, susp_s, therm_m, therm_s} <= 4'hc;
            {req_m, req_s, clr_m, clr_s, clr_d} <= 5'h00;
        end
        else
        begin
            pin_m <= i_io_pin;
            pin_s <= pin_m;
            pin_prev <= pin_s;
            {susp_m, susp_s} <= {i_suspend_select, susp_m};
            {therm_m, therm_s} <= {i_thermal_fault, therm_m};
            {req_m, req_s} <= {req_tgl, req_m};
            {clr_m, clr_s, clr_d} <= {clr_tgl, clr_m, clr_s};
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            mirror <= CFG_RESET;
            req_seen <= 1'b0;
        end
        else if (req_s != req_seen)
        begin
            mirror <= xfer_data;
            req_seen <= req_s;
        end
    end

    // R1 set chosen by suspend_select
    wire logic [7:0] act_out = susp_s ? mirror[7:0] : mirror[31:24];
    wire logic [7:0] act_rise = susp_s ? mirror[15:8] : mirror[39:32];
    wire logic [7:0] act_fall = susp_s ? mirror[23:16] : mirror[47:40];
    wire logic clr_pulse = clr_s ^ clr_d;
    // R3 R4 R25 per-pin edges gated by masks
    wire logic [7:0] rise_ok = pin_s & ~pin_prev & ~act_rise;
    wire logic [7:0] fall_ok = ~pin_s & pin_prev & ~act_fall;

    // R2 R8 R12 sticky flags, set beats clear
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            pend_rise <= 8'h00;
            pend_fall <= 8'h00;
            pend_therm <= 1'b0;
        end
        else
        begin
            pend_rise <= (pend_rise & ~{8{clr_pulse}}) | rise_ok;
            pend_fall <= (pend_fall & ~{8{clr_pulse}}) | fall_ok;
            // R6 unmasked thermal flag
            pend_therm <= (pend_therm & ~clr_pulse) | therm_s;
        end
    end

    // R14 R21 open-drain drive, released when hot
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_io_oe <= ~OUT_RESET;
            o_io_out <= 8'h00;
            o_alert_oe <= 1'b0;
        end
        else
        begin
            o_io_oe <= therm_s ? 8'h00 : ~act_out;
            o_io_out <= 8'h00;
            // R11 alert held until cleared
            o_alert_oe <= |{pend_rise, pend_fall, pend_therm};
        end
    end

    // ****************************************
    // checks
    // ****************************************
    sequence s_hot3;
        therm_s [*3];
    endsequence

    property p_thermal_alert;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        s_hot3 |-> ##[0:2] o_alert_oe;
    endproperty
    a_thermal_alert: assert property (p_thermal_alert) else $error("thermal without alert"); // R6

    property p_mask_keeps;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (|pend_rise && !clr_pulse) |=> (pend_rise & $past(pend_rise)) == $past(pend_rise);
    endproperty
    a_mask_keeps: assert property (p_mask_keeps) else $error("pending lost without clear"); // R8

    property p_rise_masked;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        ##1 (pend_rise & ~$past(pend_rise) & ~$past(rise_ok)) == 8'h00;
    endproperty
    a_rise_masked: assert property (p_rise_masked) else $error("masked rise latched"); // R3

    property p_fall_masked;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        ##1 (pend_fall & ~$past(pend_fall) & ~$past(fall_ok)) == 8'h00;
    endproperty
    a_fall_masked: assert property (p_fall_masked) else $error("masked fall latched"); // R4

    property p_clear;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (clr_pulse && !therm_s && rise_ok == 8'h00 && fall_ok == 8'h00) |=>
            !(|pend_rise) && !(|pend_fall) && !pend_therm ##1 !o_alert_oe || therm_s;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not drop alert"); // R7

    property p_suspend_out;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (!susp_s && !therm_s) |=> o_io_oe == ~$past(mirror[31:24]) || $past(therm_s);
    endproperty
    a_suspend_out: assert property (p_suspend_out) else $error("suspend set not applied"); // R1

    property p_soft_por;
        @(posedge i_link_clk) disable iff (!i_rst_n)
        (soft_por && !wr_evt) |=> cfg[1] == smbus_io_expander_pkg::MASK_RESET &&
            cfg[5] == smbus_io_expander_pkg::MASK_RESET && cfg[0] == OUT_RESET &&
            cmd_ptr == $past(cmd_ptr);
    endproperty
    a_soft_por: assert property (p_soft_por) else $error("soft reset wrong"); // R18

    property p_redirect;
        @(posedge i_link_clk) disable iff (!i_rst_n)
        (wr_evt && cmd_ptr > smbus_io_expander_pkg::CMD_LAST_DATA) |=> cfg[0] == $past(shift);
    endproperty
    a_redirect: assert property (p_redirect) else $error("write not redirected"); // R23

    property p_arb_release;
        @(posedge i_link_clk) disable iff (!i_rst_n)
        (lost && st == smbus_io_expander_pkg::ST_TX && edge_ok) |=> !o_sda_oe ##1 !o_sda_oe;
    endproperty
    a_arb_release: assert property (p_arb_release) else $error("loser still drives"); // R10

endmodule : smbus_io_expander_core

`default_nettype wire

// *** verilog/smbus_io_expander_pkg.sv ***
// constants and types shared by the smbus i/o expander core
package smbus_io_expander_pkg;

    // ****************************************
    // command bytes
    // ****************************************
    localparam logic [7:0] CMD_NORMAL_OUT = 8'h00;
    localparam logic [7:0] CMD_NORMAL_RISE = 8'h01;
    localparam logic [7:0] CMD_NORMAL_FALL = 8'h02;
    localparam logic [7:0] CMD_SUSPEND_OUT = 8'h03;
    localparam logic [7:0] CMD_SUSPEND_RISE = 8'h04;
    localparam logic [7:0] CMD_SUSPEND_FALL = 8'h05;
    localparam logic [7:0] CMD_PIN_LEVEL = 8'h06;
    localparam logic [7:0] CMD_ADDR_RESAMPLE = 8'h07;
    localparam logic [7:0] CMD_SOFT_POR = 8'h08;
    localparam logic [7:0] CMD_MAKER_ID = 8'hfe;
    localparam logic [7:0] CMD_LAST_DATA = 8'h05;

    // ****************************************
    // reset values and addresses
    // ****************************************
    localparam logic [7:0] CMD_PTR_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'hff;
    localparam logic [7:0] OUT_RESET_LOW = 8'h00;
    localparam logic [7:0] OUT_RESET_HIGH = 8'hff;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam logic [6:0] ALERT_RESPONSE_ADDR = 7'h19;
    localparam logic [6:0] SLAVE_ADDR_BASE = 7'h20;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // ****************************************
    // link state machine
    // ****************************************
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_ACK = 4'h3,
        ST_CMD = 4'h2,
        ST_CMD_ACK = 4'h6,
        ST_DATA = 4'h7,
        ST_DATA_ACK = 4'h5,
        ST_TX = 4'h4,
        ST_TX_ACK = 4'hc
    } link_state_e;

endpackage : smbus_io_expander_pkg
